// ==== hw/pirc_top.sv ====
// Priority interrupt controller with master-reset entry and AXI4-Lite registers
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module pirc_top (
  input  wire logic                      CLK_I,
  input  wire logic                      NRST_I,
  input  wire logic                      CE_I,
  input  wire logic [pirc_pkg::NSRC-1:0] SRC_I,
  input  wire logic [pirc_pkg::NRSRC-1:0] RST_SRC_I,
  input  wire pirc_pkg::pirc_core_cmd_t  CORE_CMD_I,
  output      pirc_pkg::pirc_core_req_t  CORE_REQ_O,
  output      logic                      MCYC_PH_O,
  output      logic                      IO_RESET_O,
  output      logic                      PORT_IN_MODE_O,
  input  wire logic [7:0]                S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output      logic                      S_AXI_AWREADY,
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output      logic                      S_AXI_WREADY,
  output      logic [1:0]                S_AXI_BRESP,
  output      logic                      S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  input  wire logic [7:0]                S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output      logic                      S_AXI_ARREADY,
  output      logic [31:0]               S_AXI_RDATA,
  output      logic [1:0]                S_AXI_RRESP,
  output      logic                      S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY
);

  pirc_pkg::pirc_state_t s_r;                    // Registered state
  pirc_pkg::pirc_state_t s_nxt;                  // Next state

  // Byte-lane merge of a bus write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Next-state logic for the whole controller
  always_comb begin
    logic [7:0]  cand;                           // Pending but not in service
    logic [2:0]  sel;                            // Highest candidate level
    logic        found;                          // Any candidate at all
    logic        blk;                            // Higher level in service
    logic [2:0]  hi;                             // Highest active level
    logic [31:0] w;                              // Merged write word
    logic        hit;                            // Mapped address
    cand  = '0;
    sel   = '0;
    found = 1'b0;
    blk   = 1'b0;
    hi    = '0;
    w     = '0;
    hit   = 1'b0;
    s_nxt = s_r;
    // Two clocks per machine cycle
    s_nxt.ph = ~s_r.ph;
    // Reset sources come from outside the clock domain
    s_nxt.rs1 = RST_SRC_I;
    s_nxt.rs2 = s_r.rs1;
    // Bus reset only for the power-on phase
    s_nxt.io_rst = 1'b0;
    // Requests between samples are held until the next sample
    s_nxt.hold = s_r.hold | SRC_I;

    // Global flag from enable, sleep and disable instructions
    if (CORE_CMD_I.di) begin
      s_nxt.gie = 1'b0;
    end else if (CORE_CMD_I.ei) begin
      s_nxt.gie = 1'b1;
    end

    // Return clears the level in service, the highest active one
    if (CORE_CMD_I.return_from_interrupt_op) begin
      for (int i = 0; i < pirc_pkg::NLVL; i++) begin
        if (s_r.act[i]) begin
          hi = 3'(i);
        end
      end
      if (|s_r.act) begin
        s_nxt.act[hi]  = 1'b0;
        s_nxt.pend[hi] = 1'b0;
      end
    end

    // Acknowledge cycle: boot call first, then normal service
    if (CORE_CMD_I.ack) begin
      if (s_r.mode == pirc_pkg::MD_BOOT) begin
        s_nxt.mode = pirc_pkg::MD_RUN;
      end else if (s_r.req.irq) begin
        s_nxt.act[s_r.req.level] = 1'b1;
      end
    end

    // Sampling after clears, so a fresh request wins over a return
    // I/O cycles own the bus, so no sample then; adds to the latency
    if (CORE_CMD_I.instr_end && !CORE_CMD_I.io_instr) begin
      for (int j = 0; j < pirc_pkg::NSRC; j++) begin
        if (s_r.hold[j] && !s_r.mask[j]) begin
          s_nxt.pend[pirc_pkg::SRC_LVL[j]] = 1'b1;
        end
      end
      s_nxt.hold = SRC_I;
    end

    // Software interrupt goes straight to the pending bits
    if (CORE_CMD_I.software_interrupt_op) begin
      s_nxt.pend = s_nxt.pend | CORE_CMD_I.swi_data;
    end

    // Write channels: address and data taken in either order
    if (s_r.awready && S_AXI_AWVALID) begin
      s_nxt.awready = 1'b0;
      s_nxt.awaddr  = S_AXI_AWADDR;
    end
    if (s_r.wready && S_AXI_WVALID) begin
      s_nxt.wready = 1'b0;
      s_nxt.wdata  = S_AXI_WDATA;
      s_nxt.wstrb  = S_AXI_WSTRB;
    end
    // Both halves held: perform the write and answer
    if (!s_r.awready && !s_r.wready && !s_r.bvalid) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = pirc_pkg::RESP_OKAY;
      unique case (s_r.awaddr)
        pirc_pkg::OFS_CTRL: begin
          w = merge({31'h0, s_r.gie}, s_r.wdata, s_r.wstrb);
          s_nxt.gie = w[pirc_pkg::CTRL_GIE_BIT];
        end
        pirc_pkg::OFS_MASK: begin
          w = merge({21'h0, s_r.mask}, s_r.wdata, s_r.wstrb);
          s_nxt.mask = w[pirc_pkg::NSRC-1:0];
        end
        // Status registers ignore writes
        pirc_pkg::OFS_PEND, pirc_pkg::OFS_ACT, pirc_pkg::OFS_STAT: begin
          s_nxt.bresp = pirc_pkg::RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = pirc_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Response taken: reopen both channels
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid  = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end

    // Read channel answers one cycle after the address
    if (s_r.arready && S_AXI_ARVALID) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rresp   = pirc_pkg::RESP_OKAY;
      s_nxt.rdata   = '0;
      hit = 1'b1;
      unique case (S_AXI_ARADDR)
        pirc_pkg::OFS_CTRL: s_nxt.rdata[pirc_pkg::CTRL_GIE_BIT] = s_r.gie;
        pirc_pkg::OFS_MASK: s_nxt.rdata[pirc_pkg::NSRC-1:0] = s_r.mask;
        pirc_pkg::OFS_PEND: s_nxt.rdata[7:0] = s_r.pend;
        pirc_pkg::OFS_ACT:  s_nxt.rdata[7:0] = s_r.act;
        pirc_pkg::OFS_STAT: begin
          s_nxt.rdata[pirc_pkg::STAT_IRQ_BIT]  = s_r.req.irq;
          s_nxt.rdata[pirc_pkg::STAT_BOOT_BIT] = s_r.req.boot;
          s_nxt.rdata[pirc_pkg::STAT_LVL_LSB +: 3] = s_r.req.level;
        end
        default: hit = 1'b0;
      endcase
      if (!hit) begin
        s_nxt.rresp = pirc_pkg::RESP_SLVERR;
      end
    end
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // Any synchronous reset source overrides the enable, pending, active, held and mode state; masks and bus channels carry on
    if (|s_r.rs2) begin
      s_nxt.gie  = 1'b0;
      s_nxt.pend = '0;
      s_nxt.act  = '0;
      s_nxt.hold = '0;
      s_nxt.mode = pirc_pkg::MD_BOOT;
    end

    // Pick the highest pending level not already in service
    cand = s_nxt.pend & ~s_nxt.act;
    for (int i = 0; i < pirc_pkg::NLVL; i++) begin
      if (cand[i]) begin
        sel   = 3'(i);
        found = 1'b1;
      end
    end
    for (int i = 0; i < pirc_pkg::NLVL; i++) begin
      if (s_nxt.act[i] && (3'(i) > sel)) begin
        blk = 1'b1;
      end
    end
    // Request is computed from next state so an acknowledge never repeats
    s_nxt.req.boot  = (s_nxt.mode == pirc_pkg::MD_BOOT);
    s_nxt.req.irq   = found && !blk && s_nxt.gie && !s_nxt.req.boot;
    s_nxt.req.level = sel;
    if (s_nxt.req.boot) begin
      s_nxt.req.op  = pirc_pkg::BOOT_OP;
      s_nxt.req.vec = pirc_pkg::BOOT_VEC;
    end else begin
      s_nxt.req.op  = pirc_pkg::OP_TAB[sel];
      if (sel == 3'h7) begin
        s_nxt.req.vec = pirc_pkg::VEC_TOP;
      end else begin
        s_nxt.req.vec = 12'((12'(sel) + 12'h001) * pirc_pkg::VEC_STEP);
      end
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s_r          <= '0;
      s_r.mask     <= pirc_pkg::MASK_RST;
      s_r.io_rst   <= 1'b1;
      s_r.awready  <= 1'b1;
      s_r.wready   <= 1'b1;
      s_r.arready  <= 1'b1;
      s_r.req.boot <= 1'b1;
      s_r.req.op   <= pirc_pkg::BOOT_OP;
      s_r.req.vec  <= pirc_pkg::BOOT_VEC;
    end else if (CE_I) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign CORE_REQ_O     = s_r.req;
  assign MCYC_PH_O      = s_r.ph;
  assign IO_RESET_O     = s_r.io_rst;
  assign PORT_IN_MODE_O = s_r.io_rst;
  assign S_AXI_AWREADY  = s_r.awready;
  assign S_AXI_WREADY   = s_r.wready;
  assign S_AXI_BVALID   = s_r.bvalid;
  assign S_AXI_BRESP    = s_r.bresp;
  assign S_AXI_ARREADY  = s_r.arready;
  assign S_AXI_RVALID   = s_r.rvalid;
  assign S_AXI_RDATA    = s_r.rdata;
  assign S_AXI_RRESP    = s_r.rresp;

endmodule : pirc_top

// ==== inc/pirc_pkg.sv ====
// Constants and carrier types of the priority interrupt and reset controller
package pirc_pkg;
  localparam int NLVL = 8;                       // Priority levels
  localparam int NSRC = 11;                      // Hardware request sources
  localparam int NRSRC = 4;                      // Synchronous master-reset sources

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;       // Global enable
  localparam logic [7:0] OFS_MASK = 8'h04;       // Source masks
  localparam logic [7:0] OFS_PEND = 8'h08;       // Pending levels, read only
  localparam logic [7:0] OFS_ACT  = 8'h0C;       // Active levels, read only
  localparam logic [7:0] OFS_STAT = 8'h10;       // Request state, read only

  // Field positions and reset values
  localparam int CTRL_GIE_BIT = 0;
  localparam int STAT_IRQ_BIT = 0;
  localparam int STAT_BOOT_BIT = 1;
  localparam int STAT_LVL_LSB = 4;
  localparam logic [NSRC-1:0] MASK_RST = 11'h7FF;  // All sources masked

  // Vectors and opcodes
  localparam logic [11:0] VEC_STEP = 12'h040;
  localparam logic [11:0] VEC_TOP  = 12'h1E0;
  localparam logic [7:0]  BOOT_OP  = 8'hC1;
  localparam logic [11:0] BOOT_VEC = 12'h008;
  localparam logic [7:0]  OP_TAB [NLVL] = '{8'hC8, 8'hD0, 8'hD8, 8'hE8, 8'hE8, 8'hF0, 8'hF8, 8'hFC};

  // Source to level map: p5 pin2, p5 pin3, timer1, serial, p4 pins,
  // timer2, t3 cmp1, t3 cmp2, t3 edge, p5 pins 0/1, supply monitor
  localparam logic [2:0] SRC_LVL [NSRC] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h5, 3'h5, 3'h6, 3'h7};

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Controller mode
  typedef enum logic {
    MD_BOOT = 1'b0,                              // Reset call outstanding
    MD_RUN  = 1'b1                               // Normal service
  } pirc_mode_t;

  // Command strobes from the core sequencer
  typedef struct packed {
    logic       instr_end;                       // Instruction cycle ends
    logic       io_instr;                        // Current instruction is I/O
    logic       ei;                              // Enable or sleep instruction
    logic       di;                              // Disable instruction
    logic       return_from_interrupt_op;                             // Return from interrupt
    logic       software_interrupt_op;                             // Software interrupt write
    logic [7:0] swi_data;                        // Two popped nibbles
    logic       ack;                             // Acknowledge cycle runs
  } pirc_core_cmd_t;

  // Request towards the core
  typedef struct packed {
    logic        irq;                            // Service wanted
    logic        boot;                           // Reset call wanted
    logic [2:0]  level;                          // Selected level
    logic [7:0]  op;                             // Short call opcode
    logic [11:0] vec;                            // Call target
  } pirc_core_req_t;

  // Whole state of the controller
  typedef struct packed {
    logic [NLVL-1:0]  pend;
    logic [NLVL-1:0]  act;
    logic             gie;
    logic [NSRC-1:0]  mask;
    logic [NSRC-1:0]  hold;
    logic             ph;
    pirc_mode_t       mode;
    logic             io_rst;
    logic [NRSRC-1:0] rs1;
    logic [NRSRC-1:0] rs2;
    pirc_core_req_t   req;
    logic             awready;
    logic             wready;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } pirc_state_t;
endpackage : pirc_pkg

// ==== tb/pirc_top_assertions.sv ====
// Concurrent checks on the core side of the controller
`timescale 1ns/1ns
module pirc_top_checker (
  input wire logic                       CLK_I,
  input wire logic                       NRST_I,
  input wire logic                       CE_I,
  input wire logic [pirc_pkg::NRSRC-1:0] RST_SRC_I,
  input wire pirc_pkg::pirc_core_cmd_t   CORE_CMD_I,
  input wire pirc_pkg::pirc_core_req_t   CORE_REQ_O,
  input wire logic                       MCYC_PH_O,
  input wire logic                       IO_RESET_O,
  input wire logic                       PORT_IN_MODE_O
);
  localparam logic [63:0] OPS = 64'hFCF8F0E8E8D8D0C8;  // Call opcode per level
  default clocking cb @(posedge CLK_I); endclocking
  // Frozen cycles owe nothing
  default disable iff (!NRST_I || !CE_I);
  a_vec_map: assert property (
    CORE_REQ_O.irq |-> CORE_REQ_O.vec == ((CORE_REQ_O.level == 3'h7) ? 12'h1E0
      : 12'h040 * ({9'h000, CORE_REQ_O.level} + 12'h001))) else $error("vector wrong for level");
  a_op_map: assert property (
    CORE_REQ_O.irq |-> CORE_REQ_O.op == OPS[CORE_REQ_O.level*8 +: 8]) else $error("opcode wrong for level");
  a_phase_toggle: assert property (
    1'h1 |=> MCYC_PH_O != $past(MCYC_PH_O)) else $error("phase stuck");
  a_port_mode: assert property (
    PORT_IN_MODE_O == IO_RESET_O && !$rose(IO_RESET_O)) else $error("port mode wrong");
  a_boot_call: assert property (
    CORE_REQ_O.boot |-> !CORE_REQ_O.irq && CORE_REQ_O.op == 8'hC1 && CORE_REQ_O.vec == 12'h008)
    else $error("reset call wrong");
  a_src_reset: assert property (
    (|RST_SRC_I) [*4] |=> CORE_REQ_O.boot && !CORE_REQ_O.irq) else $error("reset source ignored");
  a_dis_gate: assert property (
    CORE_CMD_I.di && !CORE_CMD_I.ei |=> !CORE_REQ_O.irq) else $error("request after disable");
  a_io_hold: assert property (
    CORE_CMD_I.instr_end && CORE_CMD_I.io_instr && !CORE_REQ_O.irq
      && !(CORE_CMD_I.ei | CORE_CMD_I.software_interrupt_op | CORE_CMD_I.return_from_interrupt_op) |=> !CORE_REQ_O.irq)
    else $error("sampled in I/O cycle");
  a_ack_level: assert property (
    CORE_CMD_I.ack && CORE_REQ_O.irq && !CORE_REQ_O.boot
      |=> !CORE_REQ_O.irq || CORE_REQ_O.level > $past(CORE_REQ_O.level)) else $error("lower level not held");
endmodule : pirc_top_checker

bind pirc_top pirc_top_checker i_chk (.CLK_I(CLK_I), .NRST_I(NRST_I), .CE_I(CE_I), .RST_SRC_I(RST_SRC_I),
  .CORE_CMD_I(CORE_CMD_I), .CORE_REQ_O(CORE_REQ_O), .MCYC_PH_O(MCYC_PH_O), .IO_RESET_O(IO_RESET_O),
  .PORT_IN_MODE_O(PORT_IN_MODE_O));

// ==== tb/pirc_core_model.sv ====
// Behavioural core sequencer facing the controller
`timescale 1ns/1ns
module pirc_core_model (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     auto_ack_i,  // Answer requests unasked
  input  wire pirc_pkg::pirc_core_req_t req_i,
  input  wire pirc_pkg::pirc_core_cmd_t cmd_i,       // Bench strobes
  output      pirc_pkg::pirc_core_cmd_t cmd_o
);
  logic ph_r;   // Machine cycle phase
  logic ack_r;  // Acknowledge pulse
  // One instruction end per two clocks; one ack per request, never twice running
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_r  <= 1'h0;
      ack_r <= 1'h0;
    end else begin
      ph_r  <= !ph_r;
      ack_r <= auto_ack_i && (req_i.irq || req_i.boot) && !ack_r;
    end
  end
  // Bench strobes pass, sequencer adds its own
  always_comb begin
    cmd_o           = cmd_i;
    cmd_o.instr_end = ph_r;
    cmd_o.ack       = cmd_i.ack | ack_r;
  end
endmodule : pirc_core_model

// ==== tb/pirc_top_bench.sv ====
// Self-checking bench of the priority interrupt controller
`timescale 1ns/1ns
module pirc_top_bench;
  localparam logic [63:0] OPS = 64'hFCF8F0E8E8D8D0C8;  // Call opcode per level
  localparam logic [43:0] LV  = 44'h76555433211;       // Level per source
  localparam int K_EN = 0, K_DIS = 1, K_RET = 2, K_SOFT = 3, K_ACK = 4;  // Core strobe kinds
  logic                     clk = 1'h0, nrst = 1'h0, auto_ack = 1'h1;
  logic [10:0]              src  = 11'h000;
  logic [3:0]               rsrc = 4'h0;
  pirc_pkg::pirc_core_cmd_t cmd  = '0;  // Bench part of core strobes
  pirc_pkg::pirc_core_cmd_t core_cmd;
  pirc_pkg::pirc_core_req_t req;
  logic                     mph, io_rst, port_in, awready, wready, bvalid, arready, rvalid;
  logic                     awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0]               awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]              wdata = 32'h00000000, rdata, rd_val;
  logic [1:0]               bresp, rresp, rd_resp, wr_resp;
  int                       bad_count = 0, checked = 0;

  pirc_core_model i_core (.clk_i(clk), .nrst_i(nrst), .auto_ack_i(auto_ack), .req_i(req), .cmd_i(cmd),
    .cmd_o(core_cmd));
  pirc_top i_dut (.CLK_I(clk), .NRST_I(nrst), .CE_I(1'h1), .SRC_I(src), .RST_SRC_I(rsrc), .CORE_CMD_I(core_cmd),
    .CORE_REQ_O(req), .MCYC_PH_O(mph), .IO_RESET_O(io_rst), .PORT_IN_MODE_O(port_in), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task finish_test();
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  // Bus write; each channel dropped when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    wr_resp = bresp;
  endtask : wr
  task rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd_val = rdata; rd_resp = rresp;
  endtask : rd
  // One-cycle core strobe, then a quiet edge
  task cmdp(input int k, input logic [7:0] d);
    pirc_pkg::pirc_core_cmd_t c;
    c = '0; c.ei = (k == K_EN); c.di = (k == K_DIS); c.return_from_interrupt_op = (k == K_RET);
    c.software_interrupt_op = (k == K_SOFT); c.swi_data = d; c.ack = (k == K_ACK);
    cmd <= c; @(posedge clk); cmd <= '0; @(posedge clk);
  endtask : cmdp
  task pulse(input int s);
    src <= 11'h001 << s; @(posedge clk); src <= 11'h000; @(posedge clk);
  endtask : pulse
  // Wait for a request and judge its level, opcode and vector
  task pick(input logic [2:0] l);
    for (int i = 0; i < 16 && req.irq !== 1'h1; i++) @(posedge clk);
    chk({req.irq, req.level}, {1'h1, l});
    chk(req.op, OPS[l*8 +: 8]);
    chk(req.vec, (l == 3'h7) ? 12'h1E0 : 12'h040 * ({9'h000, l} + 12'h001));
  endtask : pick
  task serve(input logic [2:0] l);
    pick(l);
    cmdp(K_ACK, 8'h00);
    chk(req.irq, 1'h0);
    cmdp(K_RET, 8'h00);
  endtask : serve
  task t_reset_entry();
    chk({io_rst, port_in}, 2'h3);
    chk({req.boot, req.op, req.vec}, {1'h1, 8'hC1, 12'h008});
    nrst <= 1'h1;
    repeat (8) @(posedge clk);
    chk({io_rst, req.boot}, 2'h0);
    rd(pirc_pkg::OFS_CTRL); chk(rd_val, 32'h0);
    rd(pirc_pkg::OFS_PEND); chk(rd_val, 32'h0);
    rd(8'h20); chk(rd_resp, pirc_pkg::RESP_SLVERR);
    wr(8'h20, 32'h0); chk(wr_resp, pirc_pkg::RESP_SLVERR);
    wr(pirc_pkg::OFS_MASK, 32'h0); wr(pirc_pkg::OFS_CTRL, 32'h1); auto_ack <= 1'h0;
  endtask : t_reset_entry
  task t_levels();
    for (int s = 0; s < 11; s++) begin
      pulse(s); serve(LV[s*4 +: 3]);
    end
    for (int n = 0; n < 8; n++) begin
      cmdp(K_SOFT, 8'h01 << n); serve(n[2:0]);
    end
  endtask : t_levels
  task t_priority();
    cmdp(K_DIS, 8'h00); cmdp(K_SOFT, 8'h24); repeat (4) @(posedge clk);
    chk(req.irq, 1'h0);
    rd(pirc_pkg::OFS_PEND); chk(rd_val, 32'h24);
    cmdp(K_EN, 8'h00); pick(3'h5);
    rd(pirc_pkg::OFS_STAT); chk(rd_val, 32'h51);
    cmdp(K_ACK, 8'h00);
    rd(pirc_pkg::OFS_ACT); chk({rd_val, req.irq}, {32'h20, 1'h0});
    cmdp(K_RET, 8'h00); pick(3'h2);
    rd(pirc_pkg::OFS_PEND); chk(rd_val, 32'h04);
    cmdp(K_ACK, 8'h00); cmdp(K_RET, 8'h00);
  endtask : t_priority
  task t_lost();
    cmdp(K_DIS, 8'h00); pulse(2); repeat (4) @(posedge clk); pulse(2); repeat (4) @(posedge clk);
    cmdp(K_EN, 8'h00); serve(3'h2); repeat (4) @(posedge clk);
    rd(pirc_pkg::OFS_PEND); chk({rd_val, req.irq}, 33'h0);
  endtask : t_lost
  task t_mask_io();
    wr(pirc_pkg::OFS_MASK, 32'h4); pulse(2); repeat (4) @(posedge clk);
    rd(pirc_pkg::OFS_PEND); chk(rd_val, 32'h0);
    wr(pirc_pkg::OFS_MASK, 32'h0); cmd.io_instr <= 1'h1; pulse(2); repeat (6) @(posedge clk);
    chk(req.irq, 1'h0);
    cmd.io_instr <= 1'h0; serve(3'h2);
  endtask : t_mask_io
  task t_latency();
    int n;
    auto_ack <= 1'h1; src <= 11'h020; @(posedge clk); src <= 11'h000;
    for (n = 1; n < 20 && core_cmd.ack !== 1'h1; n++) @(posedge clk);
    chk(n <= 10, 1'h1);
    auto_ack <= 1'h0; cmdp(K_RET, 8'h00);
  endtask : t_latency
  task t_reset_src();
    cmdp(K_SOFT, 8'h01); serve(3'h0); cmdp(K_SOFT, 8'h81); pick(3'h7); cmdp(K_ACK, 8'h00);
    rsrc <= 4'h2; repeat (5) @(posedge clk); rsrc <= 4'h0;
    chk({req.boot, req.irq}, 2'h2);
    auto_ack <= 1'h1; repeat (4) @(posedge clk);
    rd(pirc_pkg::OFS_CTRL); chk(rd_val, 32'h0);
    rd(pirc_pkg::OFS_ACT); chk(rd_val, 32'h0);
  endtask : t_reset_src

  // 25 MHz clock
  initial forever #20 clk = ~clk;
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    t_reset_entry(); t_levels(); t_priority(); t_lost(); t_mask_io(); t_latency(); t_reset_src();
    finish_test();
  end
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule : pirc_top_bench
